/* File: hdl/gcfg_top.sv */
// Decided for this implementation: register access over AXI4-Lite.
`include "gcfg_consts.svh"

module gcfg_top #(
  parameter logic [`GC_CNT_W-1:0] DB0_CYC  = `GC_CNT_W'(`GC_DB0_NS / `GC_CLK_NS),
  parameter logic [`GC_CNT_W-1:0] DB1_CYC  = `GC_CNT_W'(`GC_DB1_NS / `GC_CLK_NS),
  parameter logic [`GC_CNT_W-1:0] DB2_CYC  = `GC_CNT_W'(`GC_DB2_NS / `GC_CLK_NS),
  parameter logic [`GC_CNT_W-1:0] DB3_CYC  = `GC_CNT_W'(`GC_DB3_NS / `GC_CLK_NS),
  parameter logic [`GC_CNT_W-1:0] PWRX_CYC = `GC_CNT_W'(`GC_PWR_X_CYC)
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [`GC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`GC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [`GC_NPIN-1:0]   pad_in,
  output gcfg_pkg::gcfg_pad_t        pad_r,
  input  wire logic                  power_on_request_input,
  input  wire logic                  power_off_request_input,
  input  wire logic                  wake_request_input_n,
  output logic                       power_on_request_r,
  output logic                       power_off_request_r,
  output logic                       wake_request_n_r,
  output logic                       irq_r
);
  import gcfg_pkg::*;

  localparam int N = `GC_NPIN;

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [`GC_IDX_W-1:0] idx,
                               input logic [`GC_IDX_W-1:0] want);
    hit = idx == want;
  endfunction

  function automatic logic [`GC_REG_W-1:0] merge(input logic [`GC_REG_W-1:0] old,
                                                 input logic [31:0] data,
                                                 input logic [3:0]  strb);
    merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // Registers
  logic [N-1:0] dben_r;
  logic [N-1:0] pu_r;
  logic [N-1:0] pd_r;
  logic [N-1:0] mode_r;
  logic [1:0]   dbt_r;
  logic [N-1:0] dir_r;
  logic [N-1:0] pol_r;
  logic [N-1:0] dout_r;
  logic [N-1:0] sts_r;
  logic [N-1:0] msk_r;
  logic [N-1:0] lvl_r;
  logic [N-1:0] lvl_q_r;

  gcfg_bus_st_t wst_r;
  gcfg_bus_st_t rst_r;
  logic [`GC_IDX_W-1:0] ridx_r;

  // ==========================================================
  // Register view, shared by the read path and write merging
  function automatic logic [`GC_REG_W-1:0] view(input logic [`GC_IDX_W-1:0] idx);
    view = '0;
    case (idx)
      `GC_IDX_DBEN: view = {3'b000, dben_r};
      `GC_IDX_PU:   view = {3'b000, pu_r};
      `GC_IDX_PD:   view = {3'b000, pd_r};
      `GC_IDX_MODE: view = {3'b000, mode_r};
      `GC_IDX_CTRL: view[`GC_DBT_HI:`GC_DBT_LO] = dbt_r;
      `GC_IDX_DIR:  view = {3'b000, dir_r};
      `GC_IDX_POL:  view = {3'b000, pol_r};
      `GC_IDX_DOUT: view = {3'b000, dout_r};
      `GC_IDX_LVL:  view = {3'b000, lvl_r};
      `GC_IDX_STS:  view = {3'b000, sts_r};
      `GC_IDX_MSK:  view = {3'b000, msk_r};
      default:      view = '0;
    endcase
  endfunction

  function automatic logic mapped(input logic [`GC_IDX_W-1:0] idx);
    mapped = (idx >= `GC_IDX_DBEN && idx <= `GC_IDX_LVL && idx != `GC_IDX_GAP)
           || hit(idx, `GC_IDX_STS) || hit(idx, `GC_IDX_MSK);
  endfunction

  // ==========================================================
  // Write channel: address and data taken together
  logic [`GC_IDX_W-1:0] widx;
  logic                 wr_fire;
  logic [`GC_REG_W-1:0] wval;
  logic                 wr_ok;

  assign widx    = s_axi_awaddr[`GC_IDX_W+1:2];
  assign wr_fire = (wst_r == ST_TAKE) && s_axi_awvalid && s_axi_wvalid;
  assign wval    = merge(view(widx), s_axi_wdata, s_axi_wstrb);
  assign wr_ok   = mapped(widx) && !hit(widx, `GC_IDX_LVL) && !hit(widx, `GC_IDX_STS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r         <= ST_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `GC_RESP_OK;
    end else begin
      case (wst_r)
        ST_IDLE: begin
          if (s_axi_awvalid && s_axi_wvalid) begin
            wst_r         <= ST_TAKE;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
          end
        end
        ST_TAKE: begin
          wst_r         <= ST_RESP;
          s_axi_awready <= 1'b0;
          s_axi_wready  <= 1'b0;
          s_axi_bvalid  <= 1'b1;
          s_axi_bresp   <= wr_ok ? `GC_RESP_OK : `GC_RESP_ERR;
        end
        ST_RESP: begin
          if (s_axi_bready) begin
            wst_r        <= ST_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wst_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Read channel
  logic rd_fire;
  logic sts_clr;

  assign rd_fire = (rst_r == ST_TAKE) && s_axi_arvalid;
  assign sts_clr = rd_fire && hit(s_axi_araddr[`GC_IDX_W+1:2], `GC_IDX_STS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r         <= ST_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `GC_RESP_OK;
      ridx_r        <= '0;
    end else begin
      case (rst_r)
        ST_IDLE: begin
          if (s_axi_arvalid) begin
            rst_r         <= ST_TAKE;
            s_axi_arready <= 1'b1;
          end
        end
        ST_TAKE: begin
          rst_r         <= ST_RESP;
          s_axi_arready <= 1'b0;
          s_axi_rvalid  <= 1'b1;
          ridx_r        <= s_axi_araddr[`GC_IDX_W+1:2];
          s_axi_rdata   <= {16'h0000, view(s_axi_araddr[`GC_IDX_W+1:2])};
          s_axi_rresp   <= mapped(s_axi_araddr[`GC_IDX_W+1:2]) ? `GC_RESP_OK
                                                               : `GC_RESP_ERR;
        end
        ST_RESP: begin
          if (s_axi_rready) begin
            rst_r        <= ST_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: rst_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Configuration registers; reset stands in for the state machine reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dben_r <= `GC_RST_DBEN;
      pu_r   <= `GC_RST_PU;
      pd_r   <= `GC_RST_PD;
      mode_r <= `GC_RST_MODE;
      dbt_r  <= `GC_RST_DBT;
      dir_r  <= `GC_RST_DIR;
      pol_r  <= `GC_RST_POL;
      dout_r <= `GC_RST_ZERO13;
      msk_r  <= `GC_RST_ZERO13;
    end else if (wr_fire) begin
      if (hit(widx, `GC_IDX_DBEN)) dben_r <= wval[N-1:0];
      if (hit(widx, `GC_IDX_PU))   pu_r   <= wval[N-1:0];
      if (hit(widx, `GC_IDX_PD))   pd_r   <= wval[N-1:0];
      if (hit(widx, `GC_IDX_MODE)) mode_r <= wval[N-1:0];
      if (hit(widx, `GC_IDX_CTRL)) dbt_r  <= wval[`GC_DBT_HI:`GC_DBT_LO];
      if (hit(widx, `GC_IDX_DIR))  dir_r  <= wval[N-1:0];
      if (hit(widx, `GC_IDX_POL))  pol_r  <= wval[N-1:0];
      if (hit(widx, `GC_IDX_DOUT)) dout_r <= wval[N-1:0];
      if (hit(widx, `GC_IDX_MSK))  msk_r  <= wval[N-1:0];
    end
  end

  // ==========================================================
  // Input synchronisers and debounce
  logic [N-1:0]             pin_s1_r;
  logic [N-1:0]             pin_s2_r;
  logic [N-1:0]             pin_db;
  logic [`GC_NPWR-1:0]      pwr_s1_r;
  logic [`GC_NPWR-1:0]      pwr_s2_r;
  logic [`GC_NPWR-1:0]      pwr_db;
  logic [`GC_NPWR-1:0]      pwr_db2;
  logic [`GC_NPWR-1:0]      pwr_act;
  logic [`GC_CNT_W-1:0]     db_limit;

  assign db_limit = (dbt_r == 2'b00) ? DB0_CYC :
                    (dbt_r == 2'b01) ? DB1_CYC :
                    (dbt_r == 2'b10) ? DB2_CYC : DB3_CYC;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pwr_s1_r <= '0;
      pwr_s2_r <= '0;
    end else begin
      pin_s1_r <= pad_in;
      pin_s2_r <= pin_s1_r;
      pwr_s1_r <= {wake_request_input_n, power_off_request_input, power_on_request_input};
      pwr_s2_r <= pwr_s1_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_pin
      gcfg_debounce u_db (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (pin_s2_r[gi]),
        .bypass  (!dben_r[gi]),
        .limit   (db_limit),
        .dout_r  (pin_db[gi])
      );
    end
    // Power and wake requests see the common filter, then their own
    for (gi = 0; gi < `GC_NPWR; gi++) begin : g_pwr
      gcfg_debounce u_db1 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (pwr_act[gi]),
        .bypass  (1'b0),
        .limit   (db_limit),
        .dout_r  (pwr_db[gi])
      );
      gcfg_debounce u_db2 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (pwr_db[gi]),
        .bypass  (1'b0),
        .limit   (PWRX_CYC),
        .dout_r  (pwr_db2[gi])
      );
    end
  endgenerate

  // Wake is filtered active high so that reset leaves its output idle
  assign pwr_act = {~pwr_s2_r[2], pwr_s2_r[1:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_on_request_r  <= 1'b0;
      power_off_request_r <= 1'b0;
      wake_request_n_r    <= 1'b1;
    end else begin
      power_on_request_r  <= pwr_db2[0];
      power_off_request_r <= pwr_db2[1];
      wake_request_n_r    <= ~pwr_db2[2];
    end
  end

  // ==========================================================
  // Polarity, edge events, status and interrupt
  logic [N-1:0] lvl_nxt;
  logic [N-1:0] evt;
  logic [N-1:0] sts_nxt;

  // Polarity 0 means active low, so a low pin is a logical one
  assign lvl_nxt = pin_db ~^ pol_r;
  // Output pins raise no events
  assign evt     = dir_r & ((lvl_r & ~lvl_q_r)
                 | (mode_r & ~lvl_r & lvl_q_r));
  // A new event wins over the clear of a status read
  assign sts_nxt = (sts_clr ? '0 : sts_r) | evt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_r   <= '0;
      lvl_q_r <= '0;
      sts_r   <= '0;
      irq_r   <= 1'b0;
    end else begin
      lvl_r   <= lvl_nxt;
      lvl_q_r <= lvl_r;
      sts_r   <= sts_nxt;
      irq_r   <= |(sts_r & msk_r);
    end
  end

  // ==========================================================
  // Pad control; software keeps pull-up and pull-down apart
  gcfg_pad_t pad_nxt;

  assign pad_nxt.pu   = pu_r & dir_r;
  assign pad_nxt.pd   = pd_r & dir_r;
  // Open drain only ever drives low
  assign pad_nxt.dout = dout_r & ~pol_r;
  assign pad_nxt.oe_n = dir_r | (pol_r & dout_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_r <= '{dout: '0, oe_n: '1, pu: '0, pd: '0};
    end else begin
      pad_r <= pad_nxt;
    end
  end

  // ==========================================================
  // Checks
  property p_pu_input;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> (pad_r.pu & ~$past(dir_r)) == '0;
  endproperty
  a_pu_input: assert property (p_pu_input)
    else $error("Pull-up driven on an output pin");

  property p_pd_input;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> (pad_r.pd & ~$past(dir_r)) == '0;
  endproperty
  a_pd_input: assert property (p_pd_input)
    else $error("Pull-down driven on an output pin");

  property p_pull_reset;
    @(posedge aclk)
      !aresetn |=> ##1 (pad_r.pu == '0 && pad_r.pd == '0);
  endproperty
  a_pull_reset: assert property (p_pull_reset)
    else $error("Pulls not cleared after reset");

  property p_rise_sets;
    @(posedge aclk) disable iff (!aresetn)
      |(dir_r & lvl_r & ~lvl_q_r) |=> (sts_r & $past(dir_r & lvl_r & ~lvl_q_r)) != '0;
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("Rising edge on input did not set status");

  property p_fall_mode;
    @(posedge aclk) disable iff (!aresetn)
      |(dir_r & ~mode_r & ~lvl_r & lvl_q_r & ~sts_r) |=>
        (sts_r & $past(dir_r & ~mode_r & ~lvl_r & lvl_q_r & ~sts_r & ~evt)) == '0;
  endproperty
  a_fall_mode: assert property (p_fall_mode)
    else $error("Falling edge set status in rising-only mode");

  property p_dbt_limit;
    @(posedge aclk) disable iff (!aresetn)
      dbt_r == 2'b11 |-> db_limit == DB3_CYC;
  endproperty
  a_dbt_limit: assert property (p_dbt_limit)
    else $error("Debounce period does not follow the code");

  property p_evt_single;
    @(posedge aclk) disable iff (!aresetn)
      |evt |=> (evt & ~mode_r & $past(evt & ~mode_r)) == '0;
  endproperty
  a_evt_single: assert property (p_evt_single)
    else $error("Edge event lasted more than one cycle");

  property p_cmos_drive;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> (pad_r.oe_n & ~$past(dir_r) & ~$past(pol_r)) == '0;
  endproperty
  a_cmos_drive: assert property (p_cmos_drive)
    else $error("CMOS output pin not driven");

  property p_od_high;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> (~pad_r.oe_n & pad_r.dout & $past(pol_r)) == '0;
  endproperty
  a_od_high: assert property (p_od_high)
    else $error("Open-drain pin drove high");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      |(sts_r & msk_r) |=> irq_r;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Unmasked status without interrupt");

endmodule

/* File: hdl/gcfg_consts.svh */
`ifndef GCFG_CONSTS_SVH
`define GCFG_CONSTS_SVH

// ==========================================================
// Geometry
`define GC_NPIN        13
`define GC_NPWR        3
`define GC_REG_W       16
`define GC_CNT_W       19
`define GC_IDX_W       8
`define GC_ADDR_W      12

// ==========================================================
// Register indices (byte address is four times the index)
`define GC_IDX_DBEN    8'h80
`define GC_IDX_PU      8'h81
`define GC_IDX_PD      8'h82
`define GC_IDX_MODE    8'h83
`define GC_IDX_GAP     8'h84
`define GC_IDX_CTRL    8'h85
`define GC_IDX_DIR     8'h86
`define GC_IDX_POL     8'h87
`define GC_IDX_DOUT    8'h88
`define GC_IDX_LVL     8'h89
`define GC_IDX_STS     8'h90
`define GC_IDX_MSK     8'h91

// ==========================================================
// Field positions
`define GC_DBT_LO      6
`define GC_DBT_HI      7

// ==========================================================
// Reset values
`define GC_RST_DBEN    13'h1fff
`define GC_RST_PU      13'h0000
`define GC_RST_PD      13'h0000
`define GC_RST_MODE    13'h0000
`define GC_RST_DIR     13'h0ffc
`define GC_RST_POL     13'h0ffc
`define GC_RST_ZERO13  13'h0000
`define GC_RST_DBT     2'h0

// ==========================================================
// Timing
`define GC_CLK_NS      10
`define GC_DB0_NS      64000
`define GC_DB1_NS      500000
`define GC_DB2_NS      1000000
`define GC_DB3_NS      4000000
`define GC_PWR_X_CYC   1000

// ==========================================================
// Bus answers
`define GC_RESP_OK     2'h0
`define GC_RESP_ERR    2'h2

`endif

/* File: hdl/gcfg_pkg.sv */
`include "gcfg_consts.svh"

package gcfg_pkg;

  typedef struct packed {
    logic [`GC_NPIN-1:0] dout;
    logic [`GC_NPIN-1:0] oe_n;
    logic [`GC_NPIN-1:0] pu;
    logic [`GC_NPIN-1:0] pd;
  } gcfg_pad_t;

  // Gray steps idle -> take -> resp; the return resp -> idle flips both bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TAKE = 2'b01,
    ST_RESP = 2'b11
  } gcfg_bus_st_t;

endpackage

/* File: hdl/gcfg_debounce.sv */
`include "gcfg_consts.svh"

module gcfg_debounce (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 din,
  input  wire logic                 bypass,
  input  wire logic [`GC_CNT_W-1:0] limit,
  output logic                      dout_r
);
  import gcfg_pkg::*;

  logic [`GC_CNT_W-1:0] cnt_r;
  logic [`GC_CNT_W-1:0] cnt_nxt;
  logic                 differ;
  logic                 expire;

  assign differ  = din != dout_r;
  // Unless bypassed, a new level must hold a whole period before it is accepted
  assign expire  = bypass | (cnt_r >= limit - `GC_CNT_W'(1));
  assign cnt_nxt = (!differ || expire) ? '0 : cnt_r + `GC_CNT_W'(1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r  <= '0;
      dout_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      if (differ && expire) begin
        dout_r <= din;
      end
    end
  end

  property p_hold_when_same;
    @(posedge aclk) disable iff (!aresetn)
      !differ |=> $stable(dout_r);
  endproperty
  a_hold_when_same: assert property (p_hold_when_same)
    else $error("Debounced output moved without a differing input");

endmodule

/* File: sim/tb_gcfg_top.sv */
`include "gcfg_consts.svh"

`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin err_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, act, exp); end end

module tb_gcfg_top;
  timeunit 1ns;
  timeprecision 100ps;
  import gcfg_pkg::*;

  typedef struct packed {
    logic [7:0]  idx;
    logic [15:0] wd;
    logic [15:0] rd;
    logic [1:0]  resp;
  } gcfg_row_t;

  localparam int NROW   = 12;
  localparam int LIM[4] = '{4, 8, 12, 16};

  logic                  aclk;
  logic                  aresetn;
  logic [`GC_ADDR_W-1:0] s_axi_awaddr;
  logic                  s_axi_awvalid;
  logic                  s_axi_awready;
  logic [31:0]           s_axi_wdata;
  logic [3:0]            s_axi_wstrb;
  logic                  s_axi_wvalid;
  logic                  s_axi_wready;
  logic [1:0]            s_axi_bresp;
  logic                  s_axi_bvalid;
  logic                  s_axi_bready;
  logic [`GC_ADDR_W-1:0] s_axi_araddr;
  logic                  s_axi_arvalid;
  logic                  s_axi_arready;
  logic [31:0]           s_axi_rdata;
  logic [1:0]            s_axi_rresp;
  logic                  s_axi_rvalid;
  logic                  s_axi_rready;
  logic [`GC_NPIN-1:0]   pad_in;
  gcfg_pad_t             pad_r;
  logic                  power_on_request_input;
  logic                  power_off_request_input;
  logic                  wake_request_input_n;
  logic                  power_on_request_r;
  logic                  power_off_request_r;
  logic                  wake_request_n_r;
  logic                  irq_r;
  int                    err_count;
  int                    total_checks;

  // Register traffic: write, then read back; the last row hits the unmapped gap
  gcfg_row_t rows [NROW] = '{
    '{8'h81, 16'h0aaa, 16'h0aaa, `GC_RESP_OK},
    '{8'h82, 16'h1555, 16'h1555, `GC_RESP_OK},
    '{8'h83, 16'h0001, 16'h0001, `GC_RESP_OK},
    '{8'h85, 16'h0040, 16'h0040, `GC_RESP_OK},
    '{8'h85, 16'h0080, 16'h0080, `GC_RESP_OK},
    '{8'h85, 16'h00c0, 16'h00c0, `GC_RESP_OK},
    '{8'h85, 16'h0000, 16'h0000, `GC_RESP_OK},
    '{8'h86, 16'h1fff, 16'h1fff, `GC_RESP_OK},
    '{8'h87, 16'h1fff, 16'h1fff, `GC_RESP_OK},
    '{8'h80, 16'h0000, 16'h0000, `GC_RESP_OK},
    '{8'h91, 16'h1fff, 16'h1fff, `GC_RESP_OK},
    '{8'h84, 16'h1234, 16'h0000, `GC_RESP_ERR}
  };

  gcfg_top #(
    .DB0_CYC  (`GC_CNT_W'(4)),
    .DB1_CYC  (`GC_CNT_W'(8)),
    .DB2_CYC  (`GC_CNT_W'(12)),
    .DB3_CYC  (`GC_CNT_W'(16)),
    .PWRX_CYC (`GC_CNT_W'(3))
  ) u_gcfg_top (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .s_axi_awaddr            (s_axi_awaddr),
    .s_axi_awvalid           (s_axi_awvalid),
    .s_axi_awready           (s_axi_awready),
    .s_axi_wdata             (s_axi_wdata),
    .s_axi_wstrb             (s_axi_wstrb),
    .s_axi_wvalid            (s_axi_wvalid),
    .s_axi_wready            (s_axi_wready),
    .s_axi_bresp             (s_axi_bresp),
    .s_axi_bvalid            (s_axi_bvalid),
    .s_axi_bready            (s_axi_bready),
    .s_axi_araddr            (s_axi_araddr),
    .s_axi_arvalid           (s_axi_arvalid),
    .s_axi_arready           (s_axi_arready),
    .s_axi_rdata             (s_axi_rdata),
    .s_axi_rresp             (s_axi_rresp),
    .s_axi_rvalid            (s_axi_rvalid),
    .s_axi_rready            (s_axi_rready),
    .pad_in                  (pad_in),
    .pad_r                   (pad_r),
    .power_on_request_input  (power_on_request_input),
    .power_off_request_input (power_off_request_input),
    .wake_request_input_n    (wake_request_input_n),
    .power_on_request_r      (power_on_request_r),
    .power_off_request_r     (power_off_request_r),
    .wake_request_n_r        (wake_request_n_r),
    .irq_r                   (irq_r)
  );

  // ==========================================================
  // Clock and verdict
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic print_verdict;
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    err_count++;
    print_verdict();
  end

  // ==========================================================
  // Bus tasks; each starts one edge late so no signal is set twice in a step
  task automatic axi_wr(input logic [7:0] idx, input logic [15:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= {2'b00, idx, 2'b00};
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    if (n >= 200) err_count++;
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    if (n >= 200) err_count++;
    d    = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(idx, d, r);
    `CHK(d, {16'h0000, exp})
    `CHK(r, er)
  endtask

  task automatic wr_ok(input logic [7:0] idx, input logic [15:0] d);
    logic [1:0] r;
    axi_wr(idx, d, r);
    `CHK(r, `GC_RESP_OK)
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic check_defaults;
    `CHK({power_on_request_r, power_off_request_r, wake_request_n_r}, 3'b001)
    rd_chk(8'h81, 16'h0000, `GC_RESP_OK);
    rd_chk(8'h82, 16'h0000, `GC_RESP_OK);
    rd_chk(8'h83, 16'h0000, `GC_RESP_OK);
    rd_chk(8'h85, 16'h0000, `GC_RESP_OK);
    rd_chk(8'h86, 16'h0ffc, `GC_RESP_OK);
    rd_chk(8'h80, 16'h1fff, `GC_RESP_OK);
    `CHK(pad_r.pu, 13'h0000)
    `CHK(pad_r.pd, 13'h0000)
    `CHK(irq_r, 1'b0)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [1:0]  r;
    logic [31:0] d;
    err_count = 0;
    total_checks = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h3;
    pad_in = '0;
    power_on_request_input = 1'b0;
    power_off_request_input = 1'b0;
    wake_request_input_n = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    check_defaults();
    for (int i = 0; i < NROW; i++) begin
      axi_wr(rows[i].idx, rows[i].wd, r);
      `CHK(r, rows[i].resp)
      rd_chk(rows[i].idx, rows[i].rd, rows[i].resp);
    end
    axi_wr(8'h89, 16'h1fff, r);
    `CHK(r, `GC_RESP_ERR)
    // Pulls follow the register only while the pin is an input
    wait_cyc(3);
    `CHK(pad_r.pu, 13'h0aaa)
    `CHK(pad_r.pd, 13'h1555)
    `CHK(pad_r.oe_n, 13'h1fff)
    wr_ok(8'h86, 16'h0000);
    wait_cyc(3);
    `CHK(pad_r.pu, 13'h0000)
    `CHK(pad_r.pd, 13'h0000)
    `CHK(pad_r.oe_n, 13'h0000)
    // Open drain releases the pin for a one, CMOS drives it
    wr_ok(8'h88, 16'h0f0f);
    wait_cyc(3);
    `CHK(pad_r.oe_n, 13'h0f0f)
    `CHK(pad_r.dout, 13'h0000)
    wr_ok(8'h87, 16'h0000);
    wait_cyc(3);
    `CHK(pad_r.oe_n, 13'h0000)
    `CHK(pad_r.dout, 13'h0f0f)
    wr_ok(8'h87, 16'h1fff);
    wr_ok(8'h88, 16'h0000);
    wr_ok(8'h86, 16'h1fff);
    wait_cyc(10);
    axi_rd(8'h90, d, r);
    // Pin 0 both edges, pin 1 rising only
    pad_in <= 13'h0003;
    wait_cyc(10);
    `CHK(irq_r, 1'b1)
    rd_chk(8'h90, 16'h0003, `GC_RESP_OK);
    wait_cyc(3);
    `CHK(irq_r, 1'b0)
    pad_in <= 13'h0000;
    wait_cyc(10);
    rd_chk(8'h90, 16'h0001, `GC_RESP_OK);
    wr_ok(8'h91, 16'h0000);
    pad_in <= 13'h0003;
    wait_cyc(10);
    `CHK(irq_r, 1'b0)
    rd_chk(8'h90, 16'h0003, `GC_RESP_OK);
    wr_ok(8'h91, 16'h1fff);
    // Pin 2 turned active low: a low pad is an asserted level
    wr_ok(8'h87, 16'h1ffb);
    wait_cyc(10);
    rd_chk(8'h90, 16'h0004, `GC_RESP_OK);
    pad_in <= 13'h0007;
    wait_cyc(10);
    rd_chk(8'h90, 16'h0000, `GC_RESP_OK);
    wr_ok(8'h87, 16'h1fff);
    wait_cyc(10);
    axi_rd(8'h90, d, r);
    pad_in <= 13'h0003;
    wait_cyc(10);
    // Short glitch passes unfiltered while debounce is off
    pad_in <= 13'h000b;
    wait_cyc(2);
    pad_in <= 13'h0003;
    wait_cyc(10);
    rd_chk(8'h90, 16'h0008, `GC_RESP_OK);
    wr_ok(8'h80, 16'h1fff);
    for (int c = 0; c < 4; c++) begin
      wr_ok(8'h85, 16'(c << 6));
      wait_cyc(40);
      axi_rd(8'h90, d, r);
      pad_in <= 13'h000b;
      wait_cyc(LIM[c] / 2);
      pad_in <= 13'h0003;
      wait_cyc(3 * LIM[c]);
      rd_chk(8'h90, 16'h0000, `GC_RESP_OK);
      pad_in <= 13'h000b;
      wait_cyc(3 * LIM[c] + 6);
      rd_chk(8'h90, 16'h0008, `GC_RESP_OK);
      pad_in <= 13'h0003;
    end
    // Power and wake requests still carry the longest period here
    power_on_request_input <= 1'b1;
    power_off_request_input <= 1'b1;
    wake_request_input_n <= 1'b0;
    wait_cyc(12);
    `CHK({power_on_request_r, power_off_request_r, wake_request_n_r}, 3'b001)
    wait_cyc(50);
    `CHK({power_on_request_r, power_off_request_r, wake_request_n_r}, 3'b110)
    // Reset in mid-run brings back every default
    aresetn <= 1'b0;
    wait_cyc(12);
    aresetn <= 1'b1;
    check_defaults();
    print_verdict();
  end
endmodule
